// ### common/sas_pkg.sv
// Shared constants and types for the SAR converter sequencer.
package sas_pkg;
	localparam int unsigned ADR_W = 8;

	localparam logic [7:0] OFS_MODE  = 8'h00;
	localparam logic [7:0] OFS_CHAN  = 8'h04;
	localparam logic [7:0] OFS_PINS  = 8'h08;
	localparam logic [7:0] OFS_CMPC  = 8'h0C;
	localparam logic [7:0] OFS_RFULL = 8'h10;
	localparam logic [7:0] OFS_RHIGH = 8'h14;
	localparam logic [7:0] OFS_RLOW  = 8'h18;
	localparam logic [7:0] OFS_STAT  = 8'h1C;

	localparam int unsigned MODE_PWR    = 0;
	localparam int unsigned MODE_FR_LSB = 3;
	localparam int unsigned MODE_FR_MSB = 5;
	localparam int unsigned MODE_START  = 7;

	localparam int unsigned CHAN_LSB  = 0;
	localparam int unsigned CHAN_MSB  = 3;
	localparam int unsigned CHAN_IREF = 7;

	localparam int unsigned PIN_ANA0 = 0;
	localparam int unsigned PIN_ANA1 = 8;
	localparam int unsigned PIN_DIR2 = 16;
	localparam int unsigned PIN_DIR7 = 24;
	localparam int unsigned PIN_CH6  = 6;

	localparam int unsigned CMP_EN     = 7;
	localparam int unsigned CMP_SEL_HI = 4;
	localparam int unsigned CMP_SEL_LO = 3;

	localparam int unsigned STAT_BUSY   = 0;
	localparam int unsigned STAT_SAMPLE = 1;
	localparam int unsigned STAT_NEW    = 2;
	localparam int unsigned STAT_CMP    = 3;
	localparam int unsigned STAT_TRIAL  = 16;

	localparam int unsigned CODE_W   = 10;
	localparam int unsigned CODE_MSB = 9;
	localparam int unsigned CODE_LSB = 0;
	localparam int unsigned HIGH_LSB = 2;
	localparam int unsigned LOW_MSB  = 7;

	localparam logic [9:0] SAR_FIRST     = 10'h200;
	localparam logic [9:0] CODE_LSB_MASK = 10'h001;
	localparam logic [3:0] IDX_MSB       = 4'h9;
	localparam logic [3:0] IDX_LSB       = 4'h0;
	localparam logic [3:0] NUM_BITS      = 4'hA;

	localparam logic [7:0]  MODE_RST = 8'h00;
	localparam logic [7:0]  CHAN_RST = 8'h00;
	localparam logic [31:0] PINS_RST = 32'h01FF_0000;
	localparam logic [7:0]  CMPC_RST = 8'h00;
	localparam logic [9:0]  RES_RST  = 10'h000;

	localparam int unsigned BIT_BASE_CYC   = 8;
	localparam int unsigned SAMPLE_PERIODS = 4;
	localparam int unsigned CNT_W          = 11;
	localparam logic [1:0]  SAMP_LAST      = 2'(SAMPLE_PERIODS - 1);

	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} sas_state_e;
	typedef logic [CODE_W-1:0] sas_code_t;
endpackage

// ### common/sas_eng_if.sv
// Link between the sequencer control and the approximation register engine.
`timescale 1ns/10ps
`default_nettype none
interface sas_eng_if;
	logic              load;
	logic              decide;
	logic              keep;
	sas_pkg::sas_code_t trial;
	sas_pkg::sas_code_t code;
	logic              done;

	modport ctrl (output load, output decide, output keep, input trial, input code, input done);
	modport eng (input load, input decide, input keep, output trial, output code, output done);
endinterface
`default_nettype wire

// ### verilog/sas_sar_engine.sv
// Successive approximation register making one bit decision per request.
`timescale 1ns/10ps
`default_nettype none
module sas_sar_engine (
	// Clock, reset and freeze
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic ce,
	// Sequencer side
	sas_eng_if.eng    eng
);
	sas_pkg::sas_code_t sar_q;
	sas_pkg::sas_code_t code_q;
	logic [3:0]         idx_q;
	logic [3:0]         dec_q;
	logic               done_q;
	logic               last;
	logic               fin;

	assign last = (idx_q == sas_pkg::IDX_LSB);
	assign fin  = eng.decide && last && !eng.load;

	// The trial value doubles as the reference generator setting.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sar_q <= sas_pkg::RES_RST;
			idx_q <= sas_pkg::IDX_MSB;
		end else if (ce) begin
			if (eng.load) begin
				sar_q <= sas_pkg::SAR_FIRST;
				idx_q <= sas_pkg::IDX_MSB;
			end else if (eng.decide) begin
				sar_q[idx_q] <= eng.keep;
				if (!last) begin
					sar_q[idx_q - 4'h1] <= 1'b1;
					idx_q <= idx_q - 4'h1;
				end
			end
		end
	end

	// Bit 0 is still the trial one here, so only a low comparator clears it.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			code_q <= sas_pkg::RES_RST;
			done_q <= 1'b0;
		end else if (ce) begin
			done_q <= fin;
			if (fin) begin
				code_q <= eng.keep ? sar_q : (sar_q & ~sas_pkg::CODE_LSB_MASK);
			end
		end
	end

	// Decisions since the last load, read only by the checks below.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dec_q <= 4'h0;
		end else if (ce) begin
			if (eng.load) begin
				dec_q <= 4'h0;
			end else if (eng.decide) begin
				dec_q <= dec_q + 4'h1;
			end
		end
	end

	assign eng.trial = sar_q;
	assign eng.code  = code_q;
	assign eng.done  = done_q;

	property p_first_trial;
		@(posedge clk) disable iff (sys_rst)
		(ce && eng.load) |=> (sar_q == sas_pkg::SAR_FIRST && idx_q == sas_pkg::IDX_MSB);
	endproperty
	a_first_trial: assert property (p_first_trial)
		else $error("first trial is not half scale");

	property p_msb_then_next;
		@(posedge clk) disable iff (sys_rst)
		(ce && eng.decide && !eng.load && idx_q == sas_pkg::IDX_MSB) |=>
			(sar_q[sas_pkg::CODE_MSB] == $past(eng.keep) && sar_q[sas_pkg::CODE_MSB - 1]);
	endproperty
	a_msb_then_next: assert property (p_msb_then_next)
		else $error("top bit decision or next trial bit wrong");

	property p_low_clears;
		@(posedge clk) disable iff (sys_rst)
		(ce && eng.decide && !eng.load && !last && !eng.keep) |=> !sar_q[$past(idx_q)];
	endproperty
	a_low_clears: assert property (p_low_clears)
		else $error("trial bit kept although comparator was low");

	property p_ten_bits;
		@(posedge clk) disable iff (sys_rst)
		$rose(done_q) |-> (dec_q == sas_pkg::NUM_BITS);
	endproperty
	a_ten_bits: assert property (p_ten_bits)
		else $error("code finished after a wrong number of decisions");
endmodule
`default_nettype wire

// ### verilog/sas_sequencer.sv
// Sequencer of the successive-approximation converter with its Wishbone registers.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Channel 6 reaches comparator common input only with both mode bits and analog input.
// - Mode register bit 0 powers and enables the comparator stage.
// - Writing start bit 1 begins converting the selected channel at once.
// - Sample for a fixed interval, then hold until the conversion ends.
// - First comparison sets code bit 9, reference at half scale.
// - Top bit stays set if input is at least half reference, else cleared.
// - Bit 8 tried next; reference three quarters or one quarter by bit 9.
// - Each trial bit kept when input is at least the reference, else cleared.
// - Trials continue down to bit 0, giving a 10-bit code.
// - Finished code is copied into the result registers and held.
// - Each result transfer raises the conversion-end request.
// - Conversions repeat from sampling while start stays set; clearing it stops.
// - Channel register write aborts the conversion; restarts if start is set.
// - Reset clears the full result to 0000H and byte views to 00H.
// - Full result holds the 10-bit code; byte views give upper and lower eight.
module sas_sequencer (
	// Clock, reset and freeze
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        ce,
	// Wishbone slave
	input  wire logic        wb_cyc,
	input  wire logic        wb_stb,
	input  wire logic        wb_we,
	input  wire logic [7:0]  wb_adr,
	input  wire logic [3:0]  wb_sel,
	input  wire logic [31:0] wb_wdata,
	output logic      [31:0] wb_rdata,
	output logic             wb_ack,
	// Analog front end
	input  wire logic        cmp_out,
	output logic             comparator_power_on,
	output logic             sample_hold_sample,
	output logic      [9:0]  ref_code,
	output logic      [3:0]  channel_sel,
	output logic             internal_ref_select,
	output logic             ch6_to_comparator_common,
	// Event
	output logic             conversion_end_irq
);
	sas_eng_if eng_if ();

	sas_pkg::sas_state_e state_q;
	logic [7:0]          mode_q;
	logic [7:0]          chan_q;
	logic [31:0]         pins_q;
	logic [7:0]          cmpc_q;
	sas_pkg::sas_code_t  res_q;
	logic                new_q;
	logic                irq_q;
	logic                route_q;
	logic                ack_q;
	logic [31:0]         rdata_q;
	logic [31:0]         rd_val;
	logic [31:0]         wmerge;
	logic [7:0]          adr;
	logic                req;
	logic                wr_hit;
	logic                rd_done;
	logic                chan_wr;
	logic                start;
	logic [2:0]          fr;
	logic [10:0]         per_m1;
	logic [10:0]         cnt_q;
	logic [1:0]          samp_q;
	logic                tick;
	logic                latch;
	logic                cmp_s1;
	logic                cmp_s2;
	logic                cmp_s3;
	logic                cmp_q;

	function automatic logic [31:0] sas_merge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0]  sel
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Bus decode. Only the low two address bits are ignored, so each register answers at four byte addresses.
	assign adr     = {wb_adr[7:2], 2'h0};
	assign req     = wb_cyc && wb_stb;
	assign wr_hit  = req && wb_we && ack_q;
	assign rd_done = req && !wb_we && ack_q;
	assign chan_wr = wr_hit && (adr == sas_pkg::OFS_CHAN);
	assign wmerge  = sas_merge(rd_val, wb_wdata, wb_sel);

	// One wait state: ack follows the request by one cycle and drops after one.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ack_q <= 1'b0;
		end else if (ce) begin
			ack_q <= req && !ack_q;
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		case (adr)
			sas_pkg::OFS_MODE: rd_val = 32'(mode_q);
			sas_pkg::OFS_CHAN: rd_val = 32'(chan_q);
			sas_pkg::OFS_PINS: rd_val = pins_q;
			sas_pkg::OFS_CMPC: rd_val = 32'(cmpc_q);
			sas_pkg::OFS_RFULL: rd_val = 32'(res_q);
			sas_pkg::OFS_RHIGH: rd_val = 32'(res_q[sas_pkg::CODE_MSB:sas_pkg::HIGH_LSB]);
			sas_pkg::OFS_RLOW: rd_val = 32'(res_q[sas_pkg::LOW_MSB:sas_pkg::CODE_LSB]);
			sas_pkg::OFS_STAT: begin
				rd_val[sas_pkg::STAT_BUSY] = (state_q != sas_pkg::ST_IDLE);
				rd_val[sas_pkg::STAT_SAMPLE] = (state_q == sas_pkg::ST_SAMPLE);
				rd_val[sas_pkg::STAT_NEW] = new_q;
				rd_val[sas_pkg::STAT_CMP] = cmp_q;
				rd_val[sas_pkg::STAT_TRIAL +: sas_pkg::CODE_W] = eng_if.trial;
			end
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// Read data is captured in the request cycle and stands through the ack.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (ce && req && !ack_q) begin
			rdata_q <= wb_we ? 32'h0000_0000 : rd_val;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_q <= sas_pkg::MODE_RST;
		end else if (ce && wr_hit && adr == sas_pkg::OFS_MODE) begin
			mode_q <= wmerge[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			chan_q <= sas_pkg::CHAN_RST;
		end else if (ce && chan_wr) begin
			chan_q <= wmerge[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pins_q <= sas_pkg::PINS_RST;
		end else if (ce && wr_hit && adr == sas_pkg::OFS_PINS) begin
			pins_q <= wmerge;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmpc_q <= sas_pkg::CMPC_RST;
		end else if (ce && wr_hit && adr == sas_pkg::OFS_CMPC) begin
			cmpc_q <= wmerge[7:0];
		end
	end

	// The comparator is asynchronous; a level counts once two late stages agree.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmp_s1 <= 1'b0;
			cmp_s2 <= 1'b0;
			cmp_s3 <= 1'b0;
			cmp_q  <= 1'b0;
		end else if (ce) begin
			cmp_s1 <= cmp_out;
			cmp_s2 <= cmp_s1;
			cmp_s3 <= cmp_s2;
			if (cmp_s2 == cmp_s3) begin
				cmp_q <= cmp_s3;
			end
		end
	end

	// Conversion clock period from the time field; the shortest period covers
	// the comparator synchroniser latency.
	assign start  = mode_q[sas_pkg::MODE_START];
	assign fr     = mode_q[sas_pkg::MODE_FR_MSB:sas_pkg::MODE_FR_LSB];
	assign per_m1 = sas_pkg::CNT_W'((sas_pkg::BIT_BASE_CYC << fr) - 1);
	assign tick   = (cnt_q == per_m1);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= sas_pkg::ST_IDLE;
			cnt_q   <= 11'h000;
			samp_q  <= 2'h0;
		end else if (ce) begin
			cnt_q <= tick ? 11'h000 : cnt_q + 11'h001;
			if (!start) begin
				state_q <= sas_pkg::ST_IDLE;
				cnt_q   <= 11'h000;
				samp_q  <= 2'h0;
			end else if (chan_wr) begin
				state_q <= sas_pkg::ST_SAMPLE;
				cnt_q   <= 11'h000;
				samp_q  <= 2'h0;
			end else begin
				unique case (state_q)
					sas_pkg::ST_IDLE: begin
						state_q <= sas_pkg::ST_SAMPLE;
						cnt_q   <= 11'h000;
						samp_q  <= 2'h0;
					end
					sas_pkg::ST_SAMPLE: begin
						if (tick) begin
							if (samp_q == sas_pkg::SAMP_LAST) begin
								state_q <= sas_pkg::ST_CONVERT;
								samp_q  <= 2'h0;
							end else begin
								samp_q <= samp_q + 2'h1;
							end
						end
					end
					sas_pkg::ST_CONVERT: begin
						if (eng_if.done) begin
							state_q <= sas_pkg::ST_SAMPLE;
							cnt_q   <= 11'h000;
						end
					end
				endcase
			end
		end
	end

	// Engine steps are suppressed in the cycle an abort or stop takes effect.
	assign eng_if.load   = (state_q == sas_pkg::ST_SAMPLE) && tick
		&& (samp_q == sas_pkg::SAMP_LAST) && start && !chan_wr;
	assign eng_if.decide = (state_q == sas_pkg::ST_CONVERT) && tick && start && !chan_wr;
	assign eng_if.keep   = cmp_q;

	sas_sar_engine u_eng (
		.clk     (clk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.eng     (eng_if)
	);

	// A code finished just as an abort lands is still latched, since the state leaves CONVERT only one cycle later.
	assign latch = eng_if.done && (state_q == sas_pkg::ST_CONVERT);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			res_q <= sas_pkg::RES_RST;
			irq_q <= 1'b0;
		end else if (ce) begin
			irq_q <= latch;
			if (latch) begin
				res_q <= eng_if.code;
			end
		end
	end

	// New-result flag: a completion in the same cycle as the clearing read wins.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			new_q <= 1'b0;
		end else if (ce) begin
			if (latch) begin
				new_q <= 1'b1;
			end else if (rd_done && adr == sas_pkg::OFS_RFULL) begin
				new_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			route_q <= 1'b0;
		end else if (ce) begin
			route_q <= cmpc_q[sas_pkg::CMP_SEL_HI] && cmpc_q[sas_pkg::CMP_SEL_LO]
				&& pins_q[sas_pkg::PIN_ANA0 + sas_pkg::PIN_CH6]
				&& pins_q[sas_pkg::PIN_DIR2 + sas_pkg::PIN_CH6];
		end
	end

	assign wb_ack                   = ack_q;
	assign wb_rdata                 = rdata_q;
	assign comparator_power_on      = mode_q[sas_pkg::MODE_PWR];
	assign sample_hold_sample       = (state_q == sas_pkg::ST_SAMPLE);
	assign ref_code                 = eng_if.trial;
	assign channel_sel              = chan_q[sas_pkg::CHAN_MSB:sas_pkg::CHAN_LSB];
	assign internal_ref_select      = chan_q[sas_pkg::CHAN_IREF];
	assign ch6_to_comparator_common = route_q;
	assign conversion_end_irq       = irq_q;

	property p_route;
		@(posedge clk) disable iff (sys_rst)
		(ce && ch6_to_comparator_common) |-> ($past(cmpc_q[sas_pkg::CMP_SEL_HI])
			&& $past(cmpc_q[sas_pkg::CMP_SEL_LO])
			&& $past(pins_q[sas_pkg::PIN_ANA0 + sas_pkg::PIN_CH6]));
	endproperty
	a_route: assert property (p_route)
		else $error("channel 6 routed without both mode bits and analog input");

	property p_power;
		@(posedge clk) disable iff (sys_rst)
		(ce && wr_hit && adr == sas_pkg::OFS_MODE && wb_sel[0] && wb_wdata[sas_pkg::MODE_PWR])
			|=> comparator_power_on;
	endproperty
	a_power: assert property (p_power)
		else $error("comparator not powered after enable write");

	property p_start;
		@(posedge clk) disable iff (sys_rst)
		(ce && state_q == sas_pkg::ST_IDLE && wr_hit && adr == sas_pkg::OFS_MODE && wb_sel[0]
			&& wb_wdata[sas_pkg::MODE_START]) |=> ##1 (sample_hold_sample || !$past(ce));
	endproperty
	a_start: assert property (p_start)
		else $error("start write did not begin sampling");

	property p_hold;
		@(posedge clk) disable iff (sys_rst)
		$fell(sample_hold_sample) && state_q == sas_pkg::ST_CONVERT
			|-> (ref_code == sas_pkg::SAR_FIRST);
	endproperty
	a_hold: assert property (p_hold)
		else $error("hold entered without half-scale first trial");

	property p_result;
		@(posedge clk) disable iff (sys_rst)
		(ce && latch) |=> (res_q == $past(eng_if.code) && conversion_end_irq);
	endproperty
	a_result: assert property (p_result)
		else $error("result not latched with end request");

	property p_irq_cause;
		@(posedge clk) disable iff (sys_rst)
		$rose(conversion_end_irq) |-> $past(eng_if.done);
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("end request without a finished code");

	property p_repeat;
		@(posedge clk) disable iff (sys_rst)
		(ce && latch && start && !chan_wr) |=> (state_q == sas_pkg::ST_SAMPLE && cnt_q == 11'h000);
	endproperty
	a_repeat: assert property (p_repeat)
		else $error("next conversion did not restart from sampling");

	property p_abort;
		@(posedge clk) disable iff (sys_rst)
		(ce && chan_wr && start) |=> (state_q == sas_pkg::ST_SAMPLE && cnt_q == 11'h000
			&& samp_q == 2'h0);
	endproperty
	a_abort: assert property (p_abort)
		else $error("channel write did not restart the conversion");
endmodule
`default_nettype wire

// ### sim/sas_analog_model.sv
// Behavioural sample-hold, comparator and reference generator facing the sequencer.
`timescale 1ns/10ps
`default_nettype none
module sas_analog_model (
	// Clock
	input  wire logic             clk,
	// Converter control
	input  wire logic             power_on,
	input  wire logic             sample,
	input  wire logic [9:0]       ref_code,
	input  wire logic [3:0]       channel_sel,
	// Input levels in converter steps, one per channel
	input  wire logic [15:0][9:0] levels,
	// Decision
	output logic                  cmp_out
);
	logic [9:0] held_q;

	always_ff @(posedge clk) begin
		if (sample) begin
			held_q <= levels[channel_sel];
		end
	end

	// An unpowered comparator rests low, so a start without power gives code zero.
	assign cmp_out = power_on & (held_q >= ref_code);
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the converter sequencer and its registers.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	typedef struct packed {
		logic [3:0] chan;
		logic [9:0] lvl;
	} sas_row_s;

	logic             clk;
	logic             sys_rst;
	logic             wb_cyc;
	logic             wb_stb;
	logic             wb_we;
	logic             ce;
	logic [3:0]       wb_sel;
	logic [3:0]       lanes;
	logic [7:0]       wb_adr;
	logic [31:0]      wb_wdata;
	logic [31:0]      wb_rdata;
	logic             wb_ack;
	logic             cmp_out;
	logic             pwr;
	logic             sample;
	logic [9:0]       ref_code;
	logic [3:0]       chan;
	logic             iref;
	logic             route;
	logic             irq;
	logic [15:0][9:0] levels;
	logic [31:0]      rd;
	logic [3:0]       pin_case [5];
	sas_row_s         rows [6];
	int               failures;
	int               n_checks;
	int               n_irq;
	int               span;
	int               seen;

	sas_sequencer dut_u (
		.clk(clk), .sys_rst(sys_rst), .ce(ce),
		.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
		.wb_wdata(wb_wdata), .wb_rdata(wb_rdata), .wb_ack(wb_ack),
		.cmp_out(cmp_out), .comparator_power_on(pwr), .sample_hold_sample(sample),
		.ref_code(ref_code), .channel_sel(chan), .internal_ref_select(iref),
		.ch6_to_comparator_common(route), .conversion_end_irq(irq)
	);

	sas_analog_model model_u (
		.clk(clk), .power_on(pwr), .sample(sample), .ref_code(ref_code),
		.channel_sel(chan), .levels(levels), .cmp_out(cmp_out)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		if (irq === 1'b1) begin
			n_irq <= n_irq + 1;
		end
	end

	task automatic complete_run;
		if (failures == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One classic cycle; the request stands until ack is sampled high.
	// One more edge passes after release, so register outputs have settled on return.
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_sel <= lanes;
		wb_adr <= adr;
		wb_wdata <= wd;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		rd = wb_rdata;
		check("bus ack", 1, n < 50);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wait_irq(input int limit);
		int start;
		start = n_irq;
		span = 0;
		while (n_irq == start && span < limit) begin
			@(posedge clk);
			span++;
		end
		check("conversion end", 1, n_irq != start);
	endtask

	initial begin
		sys_rst = 1'b1;
		ce = 1'b1;
		wb_sel = 4'h0;
		lanes = 4'hF;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_wdata = 32'h0000_0000;
		failures = 0;
		n_checks = 0;
		levels = '0;
		rows = '{'{4'h0, 10'h000}, '{4'h1, 10'h3FF}, '{4'h2, 10'h200},
			'{4'h3, 10'h1FF}, '{4'h5, 10'h155}, '{4'h8, 10'h2AA}};
		pin_case = '{4'hF, 4'hE, 4'hD, 4'hB, 4'h7};
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		bus(1'b0, sas_pkg::OFS_RFULL, 32'h0);
		check("full after reset", 32'h0, rd);
		bus(1'b0, sas_pkg::OFS_RHIGH, 32'h0);
		check("high after reset", 32'h0, rd);
		bus(1'b0, sas_pkg::OFS_RLOW, 32'h0);
		check("low after reset", 32'h0, rd);
		bus(1'b1, sas_pkg::OFS_RFULL, 32'h0000_03FF);
		bus(1'b0, sas_pkg::OFS_RFULL, 32'h0);
		check("read-only full", 32'h0, rd);
		bus(1'b0, 8'h20, 32'h0);
		check("unmapped", 32'h0, rd);
		bus(1'b1, sas_pkg::OFS_MODE, 32'h0000_0001);
		check("comparator power", 1, pwr);
		lanes = 4'hE;
		bus(1'b1, sas_pkg::OFS_MODE, 32'h0000_0000);
		check("byte lane kept", 1, pwr);
		lanes = 4'hF;
		repeat (12) @(posedge clk);
		foreach (rows[i]) begin
			levels[rows[i].chan] <= rows[i].lvl;
			bus(1'b1, sas_pkg::OFS_CHAN, 32'(rows[i].chan));
			check("channel", 32'(rows[i].chan), chan);
			bus(1'b1, sas_pkg::OFS_MODE, 32'h0000_0081);
			wait_irq(200);
			check("start to end", 1, span >= 105 && span <= 125);
			bus(1'b1, sas_pkg::OFS_MODE, 32'h0000_0001);
			bus(1'b0, sas_pkg::OFS_RFULL, 32'h0);
			check("full", 32'(rows[i].lvl), rd);
			bus(1'b0, sas_pkg::OFS_RHIGH, 32'h0);
			check("high", 32'(rows[i].lvl[9:2]), rd);
			bus(1'b0, sas_pkg::OFS_RLOW, 32'h0);
			check("low", 32'(rows[i].lvl[7:0]), rd);
		end
		bus(1'b1, sas_pkg::OFS_MODE, 32'h0000_0081);
		wait_irq(200);
		wait_irq(200);
		check("repeat period", 113, span);
		repeat (40) @(posedge clk);
		levels[2] <= 10'h0C3;
		bus(1'b1, sas_pkg::OFS_CHAN, 32'h0000_0002);
		wait_irq(200);
		check("abort restart", 1, span >= 105 && span <= 125);
		bus(1'b1, sas_pkg::OFS_MODE, 32'h0000_0001);
		bus(1'b0, sas_pkg::OFS_RFULL, 32'h0);
		check("after abort", 32'h0000_00C3, rd);
		seen = n_irq;
		repeat (300) @(posedge clk);
		check("stopped", seen, n_irq);
		bus(1'b1, sas_pkg::OFS_MODE, 32'h0000_0089);
		wait_irq(300);
		wait_irq(300);
		check("slow period", 225, span);
		bus(1'b1, sas_pkg::OFS_MODE, 32'h0000_0001);
		bus(1'b1, sas_pkg::OFS_CHAN, 32'h0000_0083);
		check("internal ref", 1, iref);
		foreach (pin_case[i]) begin
			bus(1'b1, sas_pkg::OFS_PINS, {9'h0, pin_case[i][2], 15'h0, pin_case[i][3], 6'h0});
			bus(1'b1, sas_pkg::OFS_CMPC, {27'h0, pin_case[i][1:0], 3'h0});
			repeat (3) @(posedge clk);
			check("common route", 32'(&pin_case[i]), route);
		end
		// A freeze of 50 cycles in the sampling phase delays the end by exactly 50.
		bus(1'b1, sas_pkg::OFS_MODE, 32'h0000_0081);
		repeat (20) @(posedge clk);
		ce <= 1'b0;
		repeat (50) @(posedge clk);
		ce <= 1'b1;
		wait_irq(300);
		check("frozen period", 95, span);
		bus(1'b0, sas_pkg::OFS_STAT, 32'h0);
		check("status busy new", 32'h0000_0005, rd & 32'h0000_0005);
		bus(1'b0, sas_pkg::OFS_RFULL, 32'h0);
		check("full channel 3", 32'h0000_01FF, rd);
		bus(1'b0, sas_pkg::OFS_STAT, 32'h0);
		check("new cleared", 32'h0000_0001, rd & 32'h0000_0005);
		// Reset in mid-run, with a non-zero result held and the converter running.
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		check("power after reset", 32'h0, pwr);
		bus(1'b0, sas_pkg::OFS_RFULL, 32'h0);
		check("full after second reset", 32'h0, rd);
		bus(1'b0, sas_pkg::OFS_RHIGH, 32'h0);
		check("high after second reset", 32'h0, rd);
		bus(1'b0, sas_pkg::OFS_RLOW, 32'h0);
		check("low after second reset", 32'h0, rd);
		seen = n_irq;
		repeat (200) @(posedge clk);
		check("idle after reset", seen, n_irq);
		complete_run();
	end

	// The tests need about 2500 cycles; this leaves ample margin.
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		complete_run();
	end
endmodule
`default_nettype wire
